// [rtl/scs_config_regs.v]
// System configuration select register bank with AXI4-Lite slave
//
// Overview of operation
// - Bus-drive select 1 makes port A pins 7..4 open-drain bus drivers; 0 normal.
// - Bus-drive pins are buffers only; any two-wire protocol is software bit-banging.
// - Timer clock source bits 1..0 combine with each timer's clock select field.
// - Vector select bit 6, reset 1: extended vector table, 0 legacy table.
// - Map select bit 5, reset 1: extended register map, 0 legacy map.
// - Extended map reaches all peripheral registers without bank-switch bits.
// - Port control bit 4, reset 0, inverts serial channel 1 transmit output.
// - Port control bit 3, reset 0, inverts serial channel 1 receive signal.
// - Port control bit 1, reset 0, selects new port behaviour when 1.
// - With extended map selected, the bus-controller access switch has no effect.
`default_nettype none
`include "scs_defines.vh"
module scs_config_regs (
	input wire mclk,
	input wire sys_rst,
	// AXI4-Lite slave
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Port A pins 7..4
	input wire [3:0] portAIn,
	input wire [3:0] portAOut,
	input wire [3:0] portAOe,
	output wire [3:0] portAPinOut,
	output wire [3:0] portAPinOe,
	output wire [3:0] portAData,
	// Serial channel 1
	input wire serialTxIn,
	output reg serial1TransmitPin,
	input wire serial1ReceivePin,
	output wire serialRxOut,
	// Timer clocking
	input wire [2:0] timerZeroClockSelect,
	input wire [2:0] timerOneClockSelect,
	output wire [4:0] timerZeroClockMode,
	output wire [4:0] timerOneClockMode,
	// Map and vector selects
	output wire vectorTableSelect,
	output wire registerMapSelect,
	output wire busCtrlAccessEnable,
	input wire keyinWakeupMapSwitch,
	output wire keyinWakeupMapEnable,
	output wire portSpecSelect
);
	reg [7:0] serialTimerControl;
	reg [7:0] vectorAndMapSelect;
	reg [7:0] portControlTwo;
	reg [11:0] awAddr;
	reg awHeld;
	reg [31:0] wData;
	reg [3:0] wStrb;
	reg wHeld;
	wire [3:0] portASync;
	wire [3:0] rxSyncBus;
	wire doWrite;
	reg [31:0] readValue;
	reg readOk;

	// =====================================================
	// AXI4-Lite write channel
	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready = !wHeld && !s_axi_bvalid;
	assign doWrite = awHeld && wHeld && !s_axi_bvalid;

	always @(posedge mclk) begin
		if (sys_rst) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= 12'h000;
			wData <= 32'h00000000;
			wStrb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SCS_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (awAddr[11:2] == `SCS_OFF_STC >> 2 || awAddr[11:2] == `SCS_OFF_VMS >> 2 ||
						awAddr[11:2] == `SCS_OFF_PC2 >> 2 || awAddr[11:2] == `SCS_OFF_STAT >> 2) begin
					s_axi_bresp <= `SCS_RESP_OKAY;
				end else begin
					s_axi_bresp <= `SCS_RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// =====================================================
	// Configuration registers
	// Only defined bits are writable; reserved bits hold their reset value
	always @(posedge mclk) begin
		if (sys_rst) begin
			serialTimerControl <= `SCS_RST_STC;
			vectorAndMapSelect <= `SCS_RST_VMS;
			portControlTwo <= `SCS_RST_PC2;
		end else if (doWrite && wStrb[0]) begin
			if (awAddr[11:2] == `SCS_OFF_STC >> 2) begin
				serialTimerControl <= (wData[7:0] & `SCS_MASK_STC) | (`SCS_RST_STC & ~`SCS_MASK_STC);
			end else if (awAddr[11:2] == `SCS_OFF_VMS >> 2) begin
				vectorAndMapSelect <= (wData[7:0] & `SCS_MASK_VMS) | (`SCS_RST_VMS & ~`SCS_MASK_VMS);
			end else if (awAddr[11:2] == `SCS_OFF_PC2 >> 2) begin
				portControlTwo <= (wData[7:0] & `SCS_MASK_PC2) | (`SCS_RST_PC2 & ~`SCS_MASK_PC2);
			end
		end
	end

	// =====================================================
	// AXI4-Lite read channel
	assign s_axi_arready = !s_axi_rvalid;

	always @* begin
		readValue = 32'h00000000;
		readOk = 1'b1;
		if (s_axi_araddr[11:2] == `SCS_OFF_STC >> 2) begin
			readValue = {24'h000000, serialTimerControl};
		end else if (s_axi_araddr[11:2] == `SCS_OFF_VMS >> 2) begin
			readValue = {24'h000000, vectorAndMapSelect};
		end else if (s_axi_araddr[11:2] == `SCS_OFF_PC2 >> 2) begin
			readValue = {24'h000000, portControlTwo};
		end else if (s_axi_araddr[11:2] == `SCS_OFF_STAT >> 2) begin
			readValue = {20'h00000, rxSyncBus, portASync, serial1TransmitPin, serialRxOut, 2'b00};
		end else begin
			readOk = 1'b0;
		end
	end

	always @(posedge mclk) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `SCS_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= readValue;
			s_axi_rresp <= readOk ? `SCS_RESP_OKAY : `SCS_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// =====================================================
	// Pin synchronisers
	scs_pin_sync #(
		.WIDTH(5)
	) uPinSync (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.pinIn({serial1ReceivePin, portAIn}),
		.pinSync({rxSyncBus[0], portASync})
	);
	assign rxSyncBus[3:1] = 3'b000;

	// =====================================================
	// Port A bus drive
	// Bus-drive mode drives low only; a high level is released to the pull-up
	// The pins stay plain buffers; any protocol is bit-banged by software
	assign portAPinOut = serialTimerControl[`SCS_BIT_BUSDRV] ? 4'h0 : portAOut;
	assign portAPinOe = serialTimerControl[`SCS_BIT_BUSDRV] ? (portAOe & ~portAOut) : portAOe;
	assign portAData = portASync;

	// =====================================================
	// Timer clock selection
	// Source bits lead the timer's own select field
	assign timerZeroClockMode = {serialTimerControl[`SCS_BIT_TCKHI], serialTimerControl[`SCS_BIT_TCKLO],
		timerZeroClockSelect};
	assign timerOneClockMode = {serialTimerControl[`SCS_BIT_TCKHI], serialTimerControl[`SCS_BIT_TCKLO],
		timerOneClockSelect};

	// =====================================================
	// Vector table and register map
	assign vectorTableSelect = vectorAndMapSelect[`SCS_BIT_VEC];
	assign registerMapSelect = vectorAndMapSelect[`SCS_BIT_MAP];
	// Extended map: both banks visible regardless of switch bits
	assign busCtrlAccessEnable = registerMapSelect | serialTimerControl[`SCS_BIT_ACCSW];
	assign keyinWakeupMapEnable = registerMapSelect | keyinWakeupMapSwitch;

	// =====================================================
	// Serial channel 1 inversion and port specification
	always @(posedge mclk) begin
		if (sys_rst) begin
			serial1TransmitPin <= 1'b1;
		end else begin
			serial1TransmitPin <= serialTxIn ^ portControlTwo[`SCS_BIT_TXINV];
		end
	end
	assign serialRxOut = rxSyncBus[0] ^ portControlTwo[`SCS_BIT_RXINV];
	assign portSpecSelect = portControlTwo[`SCS_BIT_PSPEC];
endmodule // scs_config_regs
`default_nettype wire

// [rtl/scs_defines.vh]
// Register offsets, field positions and reset values of the configuration bank
`ifndef SCS_DEFINES_VH
`define SCS_DEFINES_VH
`define SCS_OFF_STC 12'h000
`define SCS_OFF_VMS 12'h004
`define SCS_OFF_PC2 12'h008
`define SCS_OFF_STAT 12'h00c
`define SCS_RST_STC 8'h00
`define SCS_RST_VMS 8'h60
`define SCS_RST_PC2 8'h00
`define SCS_MASK_STC 8'h17
`define SCS_MASK_VMS 8'h60
`define SCS_MASK_PC2 8'h1a
`define SCS_BIT_ACCSW 4
`define SCS_BIT_BUSDRV 2
`define SCS_BIT_TCKHI 1
`define SCS_BIT_TCKLO 0
`define SCS_BIT_VEC 6
`define SCS_BIT_MAP 5
`define SCS_BIT_TXINV 4
`define SCS_BIT_RXINV 3
`define SCS_BIT_PSPEC 1
`define SCS_RESP_OKAY 2'b00
`define SCS_RESP_SLVERR 2'b10
`endif

// [rtl/scs_pin_sync.v]
// Three-stage input synchroniser with agreement of the last two stages
`default_nettype none
module scs_pin_sync #(
	parameter WIDTH = 1
) (
	input wire mclk,
	input wire sys_rst,
	input wire [WIDTH-1:0] pinIn,
	output reg [WIDTH-1:0] pinSync
);
	reg [WIDTH-1:0] stageA;
	reg [WIDTH-1:0] stageB;
	reg [WIDTH-1:0] stageC;
	genvar i;
	always @(posedge mclk) begin
		if (sys_rst) begin
			stageA <= {WIDTH{1'b0}};
			stageB <= {WIDTH{1'b0}};
			stageC <= {WIDTH{1'b0}};
		end else begin
			stageA <= pinIn;
			stageB <= stageA;
			stageC <= stageB;
		end
	end
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : gAgree
			always @(posedge mclk) begin
				if (sys_rst) begin
					pinSync[i] <= 1'b0;
				end else if (stageB[i] == stageC[i]) begin
					pinSync[i] <= stageC[i];
				end
			end
		end
	endgenerate
endmodule // scs_pin_sync
`default_nettype wire

// [testbench/scs_config_properties.sv]
// Concurrent checks on the configuration bank outputs and bus handshakes
`default_nettype none
module scs_config_props (
	input wire mclk,
	input wire sys_rst,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire [3:0] portAOut,
	input wire [3:0] portAOe,
	input wire [3:0] portAPinOut,
	input wire [3:0] portAPinOe,
	input wire serialTxIn,
	input wire serial1TransmitPin,
	input wire [2:0] timerZeroClockSelect,
	input wire [4:0] timerZeroClockMode,
	input wire [4:0] timerOneClockMode,
	input wire vectorTableSelect,
	input wire registerMapSelect,
	input wire busCtrlAccessEnable,
	input wire keyinWakeupMapEnable,
	input wire portSpecSelect
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	sequence wrTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	a_open_drain: assert property ((portAPinOut == portAOut && portAPinOe == portAOe)
		|| (portAPinOut == 4'h0 && portAPinOe == (portAOe & ~portAOut))) else $error("pin drive wrong");
	a_timer_mode: assert property (timerZeroClockMode[2:0] == timerZeroClockSelect
		&& timerOneClockMode[4:3] == timerZeroClockMode[4:3]) else $error("timer mode wrong");
	a_tx_follow: assert property (!s_axi_bvalid && !$past(sys_rst) |=>
		(serial1TransmitPin ^ $past(serial1TransmitPin)) == ($past(serialTxIn) ^ $past(serialTxIn, 2)))
		else $error("tx pin does not follow");
	a_map_bank: assert property (registerMapSelect |-> busCtrlAccessEnable) else $error("bank switch");
	a_map_keyin: assert property (registerMapSelect |-> keyinWakeupMapEnable) else $error("keyin map");
	a_write_answer: assert property (wrTaken |-> ##2 s_axi_bvalid) else $error("no write response");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read response");
	a_reset_vals: assert property ($fell(sys_rst) |-> vectorTableSelect && registerMapSelect
		&& !portSpecSelect && serial1TransmitPin) else $error("reset values wrong");
	a_sel_change: assert property ($changed({vectorTableSelect, registerMapSelect, portSpecSelect,
		timerZeroClockMode[4:3]}) |-> $rose(s_axi_bvalid) || $past(sys_rst)) else $error("select moved");
endmodule // scs_config_props
bind scs_config_regs scs_config_props u_props (.*);
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for the configuration bank
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 0, sys_rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, s_axi_bready = 1;
	logic s_axi_rready = 1, serialTxIn = 0, serial1ReceivePin = 1, keyinWakeupMapSwitch = 0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, v;
	logic [3:0] s_axi_wstrb = 4'hf, portAIn = 4'h9, portAOut = 4'ha, portAOe = 4'hf;
	logic [2:0] timerZeroClockSelect = 3'h5, timerOneClockSelect = 3'h2;
	logic [1:0] rr;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, serial1TransmitPin, serialRxOut;
	wire vectorTableSelect, registerMapSelect, busCtrlAccessEnable, keyinWakeupMapEnable, portSpecSelect;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [3:0] portAPinOut, portAPinOe, portAData;
	wire [4:0] timerZeroClockMode, timerOneClockMode;
	int n_errors = 0, checked = 0;
	scs_config_regs dut (.*);
	initial forever #4 mclk = ~mclk;
	task finish_test;
		if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(string n, logic [31:0] s, logic [31:0] e);
		checked++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(logic [11:0] a, logic [31:0] d);
		bit pa, pw;
		pa = 1;
		pw = 1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		while (pa | pw) begin
			@(posedge mclk);
			if (pa && s_axi_awready === 1'h1) begin
				pa = 0;
				s_axi_awvalid <= 1'h0;
			end
			if (pw && s_axi_wready === 1'h1) begin
				pw = 0;
				s_axi_wvalid <= 1'h0;
			end
		end
		do @(posedge mclk); while (s_axi_bvalid !== 1'h1);
		chk("bresp", s_axi_bresp, 2'h0);
	endtask
	task rd(logic [11:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do @(posedge mclk); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		do @(posedge mclk); while (s_axi_rvalid !== 1'h1);
		v = s_axi_rdata;
		rr = s_axi_rresp;
	endtask
	task rc(string n, logic [11:0] a, logic [31:0] e);
		rd(a);
		chk(n, v, e);
	endtask
	initial begin
		repeat (5000) @(posedge mclk);
		n_errors++;
		finish_test();
	end
	initial begin
		repeat (16) @(posedge mclk);
		sys_rst <= 1'h0;
		@(posedge mclk);
		rc("stc", 12'h000, 32'h0);
		rc("vms", 12'h004, 32'h60);
		rc("pc2", 12'h008, 32'h0);
		chk("rxout", serialRxOut, 1'h1);
		wr(12'h000, 32'hff);
		rc("stc", 12'h000, 32'h17);
		chk("tmr0", timerZeroClockMode, 5'h1d);
		chk("tmr1", timerOneClockMode, 5'h1a);
		chk("pinout", portAPinOut, 4'h0);
		chk("pinoe", portAPinOe, 4'h5);
		chk("pindata", portAData, 4'h9);
		wr(12'h000, 32'h0);
		chk("pinout", portAPinOut, 4'ha);
		chk("pinoe", portAPinOe, 4'hf);
		chk("bca", busCtrlAccessEnable, 1'h1);
		chk("kwu", keyinWakeupMapEnable, 1'h1);
		wr(12'h004, 32'h0);
		chk("vec", vectorTableSelect, 1'h0);
		chk("map", registerMapSelect, 1'h0);
		chk("bca", busCtrlAccessEnable, 1'h0);
		chk("kwu", keyinWakeupMapEnable, 1'h0);
		wr(12'h000, 32'h10);
		chk("bca", busCtrlAccessEnable, 1'h1);
		keyinWakeupMapSwitch <= 1'h1;
		@(posedge mclk);
		chk("kwu", keyinWakeupMapEnable, 1'h1);
		keyinWakeupMapSwitch <= 1'h0;
		wr(12'h000, 32'h0);
		chk("bca", busCtrlAccessEnable, 1'h0);
		wr(12'h004, 32'hff);
		rc("vms", 12'h004, 32'h60);
		wr(12'h008, 32'hff);
		rc("pc2", 12'h008, 32'h1a);
		chk("txpin", serial1TransmitPin, 1'h1);
		chk("spec", portSpecSelect, 1'h1);
		chk("rxout", serialRxOut, 1'h0);
		serialTxIn <= 1'h1;
		repeat (2) @(posedge mclk);
		chk("txpin", serial1TransmitPin, 1'h0);
		rd(12'h010);
		chk("unmapped", v, 32'h0);
		chk("uresp", rr, 2'h2);
		serialTxIn <= 1'h0;
		@(posedge mclk);
		sys_rst <= 1'h1;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'h0;
		@(posedge mclk);
		rc("pc2", 12'h008, 32'h0);
		chk("vec", vectorTableSelect, 1'h1);
		finish_test();
	end
endmodule // testbench
`default_nettype wire
